//--- tb/nvseq_sva.sv
// assertions on the pins of the two-wire sequencer
// assumes it is bound into nvseq and sees the bus level on SDA_IN
`timescale 1ns/10ps
module nvseq_sva #(
  parameter NV_CYCLES = 50
) (
  input wire       REF_CLK,
  input wire       RSTN,
  input wire       SCL,
  input wire       SDA_IN,
  input wire       SDA_OUT,
  input wire       SDA_OE,
  input wire [2:0] ADDRESS_SELECT_PINS,
  input wire       WP_N,
  input wire       NV_BUSY,
  input wire [7:0] CTRL1_ACTIVE,
  input wire [7:0] CTRL3_ACTIVE
);
  reg [19:0] busy_n_q;
  reg [7:0]  oe_n_q;
  reg [4:0]  stop_age_q;
  reg        sda_q;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RSTN);
  always @(posedge REF_CLK or negedge RSTN)
    if (!RSTN)
    begin
      busy_n_q   <= 20'h0_0000;
      oe_n_q     <= 8'h00;
      stop_age_q <= 5'h1f;
      sda_q      <= 1'b1;
    end
    else
    begin
      busy_n_q   <= NV_BUSY ? busy_n_q + 1'b1 : 20'h0_0000;
      oe_n_q     <= SDA_OE ? oe_n_q + 1'b1 : 8'h00;
      stop_age_q <= (SCL && SDA_IN && !sda_q) ? 5'h00 : stop_age_q + (stop_age_q != 5'h1f);
      sda_q      <= SDA_IN;
    end
  sequence busy_run;
    NV_BUSY [*8];
  endsequence
  sequence wp_held;
    !WP_N ##1 !WP_N;
  endsequence
  chk_busy_quiet: assert property (NV_BUSY |-> !SDA_OE)
    else $error("sda driven during write cycle");
  chk_open_drain: assert property (SDA_OE |-> !SDA_OUT)
    else $error("sda driven high");
  chk_busy_cause: assert property ($rose(NV_BUSY) |-> stop_age_q < 5'h10)
    else $error("write cycle without stop");
  chk_busy_hold: assert property ($rose(NV_BUSY) |-> busy_run)
    else $error("write cycle cut short");
  chk_busy_min: assert property ($fell(NV_BUSY) |-> busy_n_q >= NV_CYCLES - 2)
    else $error("write cycle too short");
  chk_busy_max: assert property (busy_n_q <= NV_CYCLES + 2)
    else $error("write cycle too long");
  chk_wp_ctrl: assert property (wp_held |-> $stable(CTRL1_ACTIVE) && $stable(CTRL3_ACTIVE))
    else $error("control changed while protected");
  chk_oe_bounded: assert property (oe_n_q <= 8'd90)
    else $error("sda held low too long");
endmodule
bind nvseq nvseq_sva #(.NV_CYCLES(NV_CYCLES)) u_sva (.REF_CLK(REF_CLK), .RSTN(RSTN),
  .SCL(SCL), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .WP_N(WP_N),
  .ADDRESS_SELECT_PINS(ADDRESS_SELECT_PINS), .NV_BUSY(NV_BUSY),
  .CTRL1_ACTIVE(CTRL1_ACTIVE), .CTRL3_ACTIVE(CTRL3_ACTIVE));

//--- tb/testbench.sv
// self-checking bench for the two-wire sequencer
// assumes twowire_master as bus master and a pull-up on sda
`timescale 1ns/10ps
`include "nvseq_regs.vh"
module testbench;
  reg         ref_clk = 1'b0;
  reg         rstn = 1'b0;
  reg         wp_n = 1'b1;
  reg  [2:0]  sel = 3'h0;
  reg  [7:0]  r;
  reg  [31:0] seed = 32'hd774_0db8;
  reg         b;
  wire        scl, pull, sda_out, sda_oe, busy;
  wire [7:0]  c1, c3;
  wire        sda = (sda_oe ? sda_out : 1'b1) & !pull;
  integer     error_cnt = 0, cmp_count = 0, mem [0:255];
  integer     v1 = 0, v3 = 0, nv1 = 0, nv3 = 0, latch = 0, per = 0;
  integer     j;
  always #20 ref_clk = ~ref_clk;
  nvseq #(.NV_CYCLES(500)) u_dut (.REF_CLK(ref_clk), .RSTN(rstn), .SCL(scl), .SDA_IN(sda),
    .SDA_OUT(sda_out), .SDA_OE(sda_oe), .ADDRESS_SELECT_PINS(sel), .WP_N(wp_n),
    .NV_BUSY(busy), .CTRL1_ACTIVE(c1), .CTRL3_ACTIVE(c3));
  twowire_master u_mst (.scl(scl), .pull(pull), .sda(sda));
  function [7:0] xs;
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    xs = seed[7:0];
  endfunction
  task chk(input string n, input [7:0] seen, input [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      $display("[ERR] %s exp %h seen %h", n, exp, seen);
      error_cnt++;
    end
  endtask
  task close_out;
    if (error_cnt == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task head(input rw);
    u_mst.start;
    u_mst.wbyte({`DEV_TYPE_ID, sel, rw}, b);
    chk("ack_sa", b, 1);
  endtask
  task wr(input [7:0] a, input integer n, input integer fd);
    integer k, ad, ok, nv;
    reg [7:0] d;
    nv = 0;
    head(0);
    u_mst.wbyte(a, b);
    chk("ack_ptr", b, 1);
    for (k = 0; k < n; k++)
    begin
      ad = {a[7:4], a[3:0] + k[3:0]};
      d = fd < 0 ? xs() : fd;
      ok = (k == 0 || a >= 8'h90) && ((latch && wp_n) || ad == 8'h86);
      u_mst.wbyte(d, b);
      chk("ack_data", b, ok[0]);
      if (ok)
      begin
        mem[ad] = d;
        if (ad >= 8'h90) nv = 1;
        if (ad == 8'h86) latch = d[7];
        if ((ad == 8'h80 || ad == 8'h85) && !per) {v1, v3} = {nv1, nv3};
        if (ad == 8'h80) per = d[7];
        if (ad == 8'h80 || ad == 8'h85) nv = 1;
        if (ad == 8'h81)
        begin
          v1 = d;
          v3 = nv3;
          if (per) nv = 1;
          if (per) nv1 = d;
        end
        if (ad == 8'h83)
        begin
          v3 = d;
          v1 = nv1;
          if (per) nv = 1;
          if (per) nv3 = d;
        end
      end
    end
    u_mst.stop;
    repeat (16) @(posedge ref_clk);
    chk("busy", busy, nv != 0);
    if (busy)
    begin
      u_mst.start;
      u_mst.wbyte({`DEV_TYPE_ID, sel, 1'b0}, b);
      chk("ack_poll", b, 0);
      u_mst.stop;
    end
    for (k = 0; k < 600 && busy; k++) @(posedge ref_clk);
    if (busy !== 1'b0) begin error_cnt++; close_out; end
    chk("ctrl1", c1, v1[7:0]);
    chk("ctrl3", c3, v3[7:0]);
  endtask
  task rd(input [7:0] a, input integer n);
    integer k, e;
    reg [7:0] d;
    head(0);
    u_mst.wbyte(a, b);
    chk("ack_ptr", b, 1);
    head(1);
    for (k = 0; k < n; k++)
    begin
      u_mst.rbyte(k < n - 1, d);
      e = (a + k == 8'h81) ? nv1 : (a + k == 8'h83) ? nv3 : mem[a + k];
      chk("rd", d, e[7:0]);
    end
    u_mst.stop;
  endtask
  initial
  begin
    for (j = 0; j < 256; j++) mem[j] = 0;
    repeat (8) @(posedge ref_clk);
    r = xs();
    rstn <= 1'b1;
    sel <= r[2:0];
    repeat (8) @(posedge ref_clk);
    rd(8'h81, 1);
    u_mst.start;
    u_mst.wbyte({`DEV_TYPE_ID, ~sel, 1'b0}, b);
    chk("ack_other", b, 0);
    u_mst.stop;
    wr(8'h90, 1, -1);
    wr(8'h86, 1, 128);
    wr(8'h9b, 18, -1);
    rd(8'h90, 16);
    wr(8'h81, 1, 8'ha5);
    rd(8'h81, 1);
    wr(8'h80, 1, 0);
    @(posedge ref_clk) wp_n <= 1'b0;
    wr(8'h81, 1, 8'h3c);
    @(posedge ref_clk) wp_n <= 1'b1;
    wr(8'h80, 1, 128);
    wr(8'h81, 1, 8'h5a);
    wr(8'h80, 1, 0);
    wr(8'h81, 1, 8'h17);
    wr(8'h83, 2, 8'hc3);
    rd(8'h81, 1);
    close_out;
  end
endmodule

//--- tb/twowire_master.sv
// behavioural two-wire bus master, 320 ns bit time
// assumes a pull-up on sda; scl stands high between frames
`timescale 1ns/10ps
module twowire_master (
  output reg  scl,
  output reg  pull,
  input  wire sda
);
  initial scl = 1'b1;
  initial pull = 1'b0;
  task put(input b);
    #47 pull = !b;
    #150 scl = 1'b1;
    #120 scl = 1'b0;
    #3;
  endtask
  task take(output b);
    #47 pull = 1'b0;
    #150 scl = 1'b1;
    #60 b = sda;
    #60 scl = 1'b0;
    #3;
  endtask
  task start;
    #47 pull = 1'b0;
    #150 scl = 1'b1;
    #60 pull = 1'b1;
    #60 scl = 1'b0;
    #3;
  endtask
  task stop;
    #47 pull = 1'b1;
    #70 scl = 1'b1;
    #80 pull = 1'b0;
    #123;
  endtask
  task wbyte(input [7:0] d, output ack);
    integer i;
    reg     b;
    for (i = 7; i >= 0; i--) put(d[i]);
    take(b);
    ack = !b;
  endtask
  task rbyte(input more, output [7:0] d);
    integer i;
    for (i = 7; i >= 0; i--) take(d[i]);
    put(!more);
  endtask
endmodule

//--- verilog/nvseq.v
// two-wire slave sequencer for a mixed volatile/nonvolatile memory
// assumes scl and sda come from pins outside the REF_CLK domain
`timescale 1ns/10ps
`include "nvseq_regs.vh"
// Functional notes
// - byte write: slave address, address, data, each acked, then STOP
// - STOP after volatile-only write is immediate; nonvolatile starts a write cycle
// - during the write cycle nothing is acked and data output stays released
// - five pages of sixteen; page writes only to the table pages
// - page write wraps the low offset counter within the page
// - bytes beyond sixteen overwrite earlier wrapped locations
// - STOP ends page loading and starts the cycle; inputs disabled meanwhile
// - control 1 and 3 are dual cell; volatile and nonvolatile cells both cleared to 00h at reset
// - persist select high writes both cells, low only volatile cells
// - persist low: write to control 0 or 5 recalls 1 and 3, unless protected
// - write to control 1 recalls 3, write to control 3 recalls 1
// - reads of control 1 and 3 return the nonvolatile cells
// - read: address write, repeated start, address read, three acks
// - data continues while master acks; master ends with STOP
// - read pointer starts at address byte and increments per data byte
// - protect pin low rejects every write except the enable latch
// - write cycle starts only after full bytes and a proper STOP
// - slave address: type id, three select bits, direction in lsb
// - no ack for data without latch except 86h, nor after a byte to any address outside the table pages
// - address polling is not acked while the write cycle runs
module nvseq #(
  parameter NV_CYCLES = `NV_WRITE_CYCLES
) (
  input  wire       REF_CLK,
  input  wire       RSTN,
  input  wire       SCL,
  input  wire       SDA_IN,
  output reg        SDA_OUT,
  output reg        SDA_OE,
  input  wire [2:0] ADDRESS_SELECT_PINS,
  input  wire       WP_N,
  output reg        NV_BUSY,
  output reg  [7:0] CTRL1_ACTIVE,
  output reg  [7:0] CTRL3_ACTIVE
);
  localparam ST_IDLE = 3'h0;
  localparam ST_SLV  = 3'h1;
  localparam ST_ADR  = 3'h2;
  localparam ST_WDAT = 3'h3;
  localparam ST_RDAT = 3'h4;
  localparam ST_SKIP = 3'h5;
  reg  [1:0]  scl_s_q;
  reg  [1:0]  sda_s_q;
  reg  [1:0]  wp_s_q;
  reg  [2:0]  as_s0_q;
  reg  [2:0]  as_s1_q;
  reg         scl_q;
  reg         sda_q;
  reg  [2:0]  st_q;
  reg  [3:0]  cnt_q;
  reg  [7:0]  sh_q;
  reg  [7:0]  tx_q;
  reg  [7:0]  ptr_q;
  reg         ack_q;
  reg         rd_ack_q;
  reg         snd_q;
  reg         first_q;
  reg         nv_pend_q;
  reg         blk_q;
  reg  [22:0] busy_cnt_q;
  reg  [7:0]  mem_q [0:63];
  reg  [7:0]  c0_q, c1v_q, c1n_q, c2_q, c3v_q, c3n_q, c4_q, c5_q, c6_q;
  reg  [7:0]  rd_byte;
  wire        scl_rise = scl_s_q[1] & ~scl_q;
  wire        scl_fall = ~scl_s_q[1] & scl_q;
  wire        start_c  = scl_q & scl_s_q[1] & sda_q & ~sda_s_q[1];
  wire        stop_c   = scl_q & scl_s_q[1] & ~sda_q & sda_s_q[1];
  wire        wp_n_s   = wp_s_q[1];
  wire [7:0]  byte_in  = {sh_q[6:0], sda_q};
  wire        latch_en = c6_q[`LATCH_BIT];
  wire        persist  = c0_q[`PERSIST_BIT];
  wire        is_c6    = (ptr_q == `CTRL6_ADDR);
  wire        is_c05   = (ptr_q == `CTRL0_ADDR) || (ptr_q == `CTRL5_ADDR);
  wire [5:0]  wr_idx   = ptr_q[5:0] - 6'h10;
  wire        b_valid, b_ready, o_valid;
  wire [13:0] o_data;
  function is_table;
    input [7:0] a;
    begin
      is_table = (a >= `TABLE_BASE) && (a <= `TABLE_LAST);
    end
  endfunction
  // receive path for accepted data bytes
  pair_buffer #(.WIDTH(14)) u_buf (
    .clk       (REF_CLK),
    .rst_n     (RSTN),
    .in_valid  (b_valid),
    .in_ready  (b_ready),
    .in_data   ({wr_idx, byte_in}),
    .out_valid (o_valid),
    .out_ready (1'b1),
    .out_data  (o_data)
  );
  wire data_byte_end = (st_q == ST_WDAT) && scl_rise && (cnt_q == 4'h7);
  wire data_ok = latch_en | is_c6;
  wire prot_ok = wp_n_s | is_c6;
  wire tab_ok  = is_table(ptr_q) | first_q;
  assign b_valid = data_byte_end & ~blk_q & data_ok & prot_ok & tab_ok;
  always @*
  begin
    case (ptr_q)
      `CTRL0_ADDR: rd_byte = c0_q;
      `CTRL1_ADDR: rd_byte = c1n_q;
      `CTRL2_ADDR: rd_byte = c2_q;
      `CTRL3_ADDR: rd_byte = c3n_q;
      `CTRL4_ADDR: rd_byte = c4_q;
      `CTRL5_ADDR: rd_byte = c5_q;
      `CTRL6_ADDR: rd_byte = c6_q;
      default:     rd_byte = is_table(ptr_q) ? mem_q[ptr_q[5:0] - 6'h10] : 8'h00;
    endcase
  end
  integer i;
  always @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      scl_s_q      <= 2'h3;
      sda_s_q      <= 2'h3;
      wp_s_q       <= 2'h3;
      as_s0_q      <= 3'h0;
      as_s1_q      <= 3'h0;
      scl_q        <= 1'b1;
      sda_q        <= 1'b1;
      st_q         <= ST_IDLE;
      cnt_q        <= 4'h0;
      sh_q         <= 8'h00;
      tx_q         <= 8'h00;
      ptr_q        <= 8'h00;
      ack_q        <= 1'b0;
      rd_ack_q     <= 1'b0;
      snd_q        <= 1'b0;
      first_q      <= 1'b0;
      nv_pend_q    <= 1'b0;
      blk_q        <= 1'b0;
      busy_cnt_q   <= 23'h00_0000;
      SDA_OUT      <= 1'b0;
      SDA_OE       <= 1'b0;
      NV_BUSY      <= 1'b0;
      c0_q         <= `CTRL0_RESET;
      c5_q         <= `CTRL5_RESET;
      c6_q         <= `CTRL6_RESET;
      c1n_q        <= 8'h00;
      c3n_q        <= 8'h00;
      c2_q         <= 8'h00;
      c4_q         <= 8'h00;
      c1v_q        <= 8'h00;
      c3v_q        <= 8'h00;
      CTRL1_ACTIVE <= 8'h00;
      CTRL3_ACTIVE <= 8'h00;
      for (i = 0; i < 64; i = i + 1)
        mem_q[i] <= 8'h00;
    end
    else
    begin
      scl_s_q      <= {scl_s_q[0], SCL};
      sda_s_q      <= {sda_s_q[0], SDA_IN};
      wp_s_q       <= {wp_s_q[0], WP_N};
      as_s0_q      <= ADDRESS_SELECT_PINS;
      as_s1_q      <= as_s0_q;
      scl_q        <= scl_s_q[1];
      sda_q        <= sda_s_q[1];
      CTRL1_ACTIVE <= c1v_q;
      CTRL3_ACTIVE <= c3v_q;
      if (NV_BUSY)
      begin
        SDA_OE <= 1'b0;
        st_q   <= ST_IDLE;
        snd_q  <= 1'b0;
        if (busy_cnt_q == 23'h00_0000)
          NV_BUSY <= 1'b0;
        else
          busy_cnt_q <= busy_cnt_q - 23'h00_0001;
      end
      else if (start_c)
      begin
        st_q   <= ST_SLV;
        cnt_q  <= 4'h0;
        snd_q  <= 1'b0;
        SDA_OE <= 1'b0;
      end
      else if (stop_c)
      begin
        st_q   <= ST_IDLE;
        snd_q  <= 1'b0;
        SDA_OE <= 1'b0;
        // only the stop's own scl rise may follow the last ack clock
        if (nv_pend_q && cnt_q == 4'h1)
        begin
          NV_BUSY    <= 1'b1;
          busy_cnt_q <= NV_CYCLES[22:0] - 23'h00_0001;
        end
        nv_pend_q <= 1'b0;
      end
      else if (scl_rise && st_q != ST_IDLE && st_q != ST_SKIP)
      begin
        if (cnt_q == 4'h8)
        begin
          cnt_q <= 4'h0;
          if (snd_q)
            rd_ack_q <= ~sda_q;
        end
        else
        begin
          sh_q  <= byte_in;
          cnt_q <= cnt_q + 4'h1;
        end
        if (cnt_q == 4'h7)
        begin
          ack_q <= 1'b0;
          case (st_q)
            ST_SLV:
            begin
              if (byte_in[7:4] == `DEV_TYPE_ID && byte_in[3:1] == as_s1_q)
              begin
                ack_q <= 1'b1;
                if (byte_in[0])
                  st_q <= ST_RDAT;
                else
                begin
                  st_q      <= ST_ADR;
                  nv_pend_q <= 1'b0;
                end
              end
              else
                st_q <= ST_SKIP;
            end
            ST_ADR:
            begin
              ptr_q   <= byte_in;
              ack_q   <= 1'b1;
              first_q <= 1'b1;
              blk_q   <= 1'b0;
              st_q    <= ST_WDAT;
            end
            ST_WDAT:
            begin
              ack_q   <= b_valid;
              first_q <= 1'b0;
              if (!is_table(ptr_q))
                blk_q <= 1'b1;
              if (b_valid && is_table(ptr_q))
              begin
                ptr_q     <= {ptr_q[7:4], ptr_q[3:0] + 4'h1};
                nv_pend_q <= 1'b1;
              end
              if (b_valid && is_c6)
                c6_q <= byte_in;
              if (b_valid && ptr_q == `CTRL0_ADDR)
                c0_q <= byte_in;
              if (b_valid && ptr_q == `CTRL5_ADDR)
                c5_q <= byte_in;
              if (b_valid && is_c05)
              begin
                nv_pend_q <= 1'b1;
                if (!persist && wp_n_s)
                begin
                  c1v_q <= c1n_q;
                  c3v_q <= c3n_q;
                end
              end
              if (b_valid && ptr_q == `CTRL1_ADDR)
              begin
                c1v_q <= byte_in;
                c3v_q <= c3n_q;
                if (persist)
                begin
                  c1n_q     <= byte_in;
                  nv_pend_q <= 1'b1;
                end
              end
              if (b_valid && ptr_q == `CTRL3_ADDR)
              begin
                c3v_q <= byte_in;
                c1v_q <= c1n_q;
                if (persist)
                begin
                  c3n_q     <= byte_in;
                  nv_pend_q <= 1'b1;
                end
              end
            end
            default:
              ack_q <= 1'b0;
          endcase
        end
      end
      else if (scl_fall && st_q != ST_IDLE && st_q != ST_SKIP)
      begin
        // eight clocks done: ack a received byte, release after a sent one
        if (cnt_q == 4'h8)
          SDA_OE <= ack_q & ~snd_q;
        else if (cnt_q == 4'h0 && st_q == ST_RDAT && (!snd_q || rd_ack_q))
        begin
          SDA_OE <= ~rd_byte[7];
          tx_q   <= {rd_byte[6:0], 1'b0};
          ptr_q  <= ptr_q + 8'h01;
          snd_q  <= 1'b1;
        end
        else if (cnt_q == 4'h0 && st_q == ST_RDAT)
        begin
          st_q   <= ST_SKIP;
          snd_q  <= 1'b0;
          SDA_OE <= 1'b0;
        end
        else if (cnt_q == 4'h0)
          SDA_OE <= 1'b0;
        else if (snd_q)
        begin
          SDA_OE <= ~tx_q[7];
          tx_q   <= {tx_q[6:0], 1'b0};
        end
      end
      if (o_valid)
        mem_q[o_data[13:8]] <= o_data[7:0];
    end
  end
endmodule

//--- verilog/nvseq_regs.vh
// constants for the two-wire memory write/read sequencer
// assumes a 25 MHz reference clock
`ifndef NVSEQ_REGS_VH
`define NVSEQ_REGS_VH
`define DEV_TYPE_ID        4'h5
`define CTRL_PAGE_BASE     8'h80
`define CTRL0_ADDR         8'h80
`define CTRL1_ADDR         8'h81
`define CTRL2_ADDR         8'h82
`define CTRL3_ADDR         8'h83
`define CTRL4_ADDR         8'h84
`define CTRL5_ADDR         8'h85
`define CTRL6_ADDR         8'h86
`define TABLE_BASE         8'h90
`define TABLE_LAST         8'hCF
`define LATCH_BIT          7
`define PERSIST_BIT        7
`define CTRL0_RESET        8'h00
`define CTRL5_RESET        8'h00
`define CTRL6_RESET        8'h00
`define NV_WRITE_US        5000
`define CLK_MHZ            25
`define NV_WRITE_CYCLES    (`NV_WRITE_US * `CLK_MHZ)
`endif

//--- verilog/pair_buffer.v
// two-entry valid/ready buffer
// assumes source and sink on the same clock
`timescale 1ns/10ps
module pair_buffer #(
  parameter WIDTH = 8
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem_q [0:1];
  reg             wp_q;
  reg             rp_q;
  reg [1:0]       cnt_q;
  wire            push;
  wire            pop;
  assign in_ready  = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data  = mem_q[rp_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wp_q     <= 1'b0;
      rp_q     <= 1'b0;
      cnt_q    <= 2'h0;
      mem_q[0] <= {WIDTH{1'b0}};
      mem_q[1] <= {WIDTH{1'b0}};
    end
    else
    begin
      if (push)
      begin
        mem_q[wp_q] <= in_data;
        wp_q        <= ~wp_q;
      end
      if (pop)
        rp_q <= ~rp_q;
      if (push & ~pop)
        cnt_q <= cnt_q + 2'h1;
      else if (pop & ~push)
        cnt_q <= cnt_q - 2'h1;
    end
  end
endmodule
